// [shift_reg_pkg.sv]
// Package with constants and carrier types for the bidirectional shift register.
package shift_reg_pkg;

  localparam int unsigned STAGES     = 8;
  localparam int unsigned WORD_WIDTH = 32;
  localparam logic        MODE_RESET = 1'b0;
  localparam int unsigned BUF_DEPTH  = 2;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef logic signed [WORD_WIDTH-1:0] word_t;

  // One shift command as it travels through the input buffer.
  typedef struct packed {
    logic  fwd;
    logic  bwd;
    logic  clr;
    logic  fwd_bit;
    logic  bwd_bit;
    word_t fwd_word;
    word_t bwd_word;
  } shift_cmd_t;

  typedef struct packed {
    logic [STAGES-1:0] bits;
  } bit_fields_t;

endpackage

// [bidirectional_shift_register.sv]
// Eight-stage bidirectional shift register with bit and double-word formats.
//
// How it works
// - Block queues no new commands while block_enable is low.
// - Each shift pulse accepted while the buffer has room loads a new value at the entry end, moving others.
// - The value at the far end is discarded on every shift.
// - Bit and double-word formats, chosen by mode, share shift and clear.
// - Bit mode uses the bit inputs and shows eight bit fields.
// - Word mode uses the word inputs and shows eight word fields.
// - Forward pulse puts forward input into field one.
// - Backward pulse puts backward input into field eight.
// - Forward shift moves field k to field k plus one.
// - Backward shift moves field k to field k minus one.
// - Clear while enabled zeroes every field in either format.
// - Word fields and inputs are signed 32-bit values.
// - Mode defaults to bit operation.
// - In bit mode word inputs and outputs have no effect.
`timescale 1ns/1ns
module bidirectional_shift_register #(
  parameter int unsigned STAGES = shift_reg_pkg::STAGES
) (
  input  wire logic                                   clk,
  input  wire logic                                   rst,
  input  wire logic                                   block_enable,
  input  wire logic                                   double_word_mode,
  input  wire logic                                   forward_shift_pulse,
  input  wire logic                                   backward_shift_pulse,
  input  wire logic                                   register_clear,
  input  wire logic                                   forward_bit_in,
  input  wire logic                                   backward_bit_in,
  input  wire shift_reg_pkg::word_t                   forward_word_in,
  input  wire shift_reg_pkg::word_t                   backward_word_in,
  input  wire logic                                   out_ready,
  output logic                                        in_ready,
  output logic                                        out_valid,
  output logic                                        mode_q,
  output logic [STAGES-1:0]                           bit_fields_q,
  output shift_reg_pkg::word_t [STAGES-1:0]           word_fields_q
);

  // ----------------------------------------------------------------------
  // Edge detection of the shift pulses
  // ----------------------------------------------------------------------
  logic fwd_prev_q;
  logic bwd_prev_q;
  wire  fwd_rise = forward_shift_pulse & ~fwd_prev_q;
  wire  bwd_rise = backward_shift_pulse & ~bwd_prev_q;

  // Edges are tracked even while disabled, so enabling with a coil held
  // high does not fake a shift.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fwd_prev_q <= 1'b0;
      bwd_prev_q <= 1'b0;
    end
    else
    begin
      fwd_prev_q <= forward_shift_pulse;
      bwd_prev_q <= backward_shift_pulse;
    end
  end

  // ----------------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------------
  // The mode is latched only while disabled, so a format change never
  // happens in the middle of a running sequence.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      mode_q <= shift_reg_pkg::MODE_RESET;
    else if (!block_enable)
      mode_q <= double_word_mode;
  end

  // ----------------------------------------------------------------------
  // Two-entry command buffer
  // ----------------------------------------------------------------------
  shift_reg_pkg::shift_cmd_t cmd_in;
  shift_reg_pkg::shift_cmd_t buf_q [shift_reg_pkg::BUF_DEPTH];
  logic [1:0] count_q;
  logic       wr_ptr_q;
  logic       rd_ptr_q;

  wire push_req = block_enable & (fwd_rise | bwd_rise | register_clear);
  wire full     = (count_q == 2'd2);
  wire empty    = (count_q == 2'd0);
  wire do_push  = push_req & ~full;
  wire do_pop   = ~empty & out_ready;

  assign cmd_in.fwd      = fwd_rise;
  assign cmd_in.bwd      = bwd_rise;
  assign cmd_in.clr      = register_clear;
  assign cmd_in.fwd_bit  = forward_bit_in;
  assign cmd_in.bwd_bit  = backward_bit_in;
  assign cmd_in.fwd_word = forward_word_in;
  assign cmd_in.bwd_word = backward_word_in;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count_q  <= 2'd0;
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end
    else
    begin
      if (do_push)
      begin
        buf_q[wr_ptr_q] <= cmd_in;
        wr_ptr_q        <= ~wr_ptr_q;
      end
      if (do_pop)
        rd_ptr_q <= ~rd_ptr_q;
      count_q <= count_q + {1'b0, do_push} - {1'b0, do_pop};
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end
    else
    begin
      in_ready  <= (count_q + {1'b0, do_push} - {1'b0, do_pop}) != 2'd2;
      out_valid <= (count_q + {1'b0, do_push} - {1'b0, do_pop}) != 2'd0;
    end
  end

  // ----------------------------------------------------------------------
  // Shift datapath
  // ----------------------------------------------------------------------
  shift_reg_pkg::shift_cmd_t cmd;
  assign cmd = buf_q[rd_ptr_q];

  // Clear has priority; a simultaneous forward and backward edge runs
  // forward only, which keeps one shift per command.
  wire apply_clr = do_pop & cmd.clr;
  wire apply_fwd = do_pop & ~cmd.clr & cmd.fwd;
  wire apply_bwd = do_pop & ~cmd.clr & ~cmd.fwd & cmd.bwd;
  wire bit_mode  = ~mode_q;
  wire word_mode = mode_q;

  logic [STAGES-1:0]                 bit_d;
  shift_reg_pkg::word_t [STAGES-1:0] word_d;

  // far-end value drops out of the concatenation.
  assign bit_d = apply_clr ? '0 :
                 apply_fwd ? {bit_fields_q[STAGES-2:0], cmd.fwd_bit} :
                 apply_bwd ? {cmd.bwd_bit, bit_fields_q[STAGES-1:1]} :
                 bit_fields_q;
  assign word_d = apply_clr ? '0 :
                  apply_fwd ? {word_fields_q[STAGES-2:0], cmd.fwd_word} :
                  apply_bwd ? {cmd.bwd_word, word_fields_q[STAGES-1:1]} :
                  word_fields_q;

  // Only the active format's storage moves; the other holds, except that a clear zeroes both.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bit_fields_q  <= '0;
      word_fields_q <= '0;
    end
    else
    begin
      if (bit_mode | apply_clr)
        bit_fields_q <= bit_d;
      if (word_mode | apply_clr)
        word_fields_q <= word_d;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_disabled_hold: assert property (
    @(posedge clk) disable iff (rst)
    (!block_enable && empty) |=> $stable(bit_fields_q)
      && $stable(word_fields_q))
    else $error("fields changed while disabled and idle");
  a_fwd_entry: assert property (
    @(posedge clk) disable iff (rst)
    (apply_fwd && bit_mode) |=> bit_fields_q[0] == $past(cmd.fwd_bit)
      && bit_fields_q[STAGES-1:1] == $past(bit_fields_q[STAGES-2:0]))
    else $error("forward bit shift wrong");
  a_bwd_entry: assert property (
    @(posedge clk) disable iff (rst)
    (apply_bwd && word_mode) |=> word_fields_q[STAGES-1] ==
      $past(cmd.bwd_word))
    else $error("backward word entry wrong");
  a_clear_zero: assert property (
    @(posedge clk) disable iff (rst)
    apply_clr |=> bit_fields_q == '0 && word_fields_q == '0)
    else $error("clear did not zero fields");
  // The queue fill level is watched rather than the push strobe, so a
  // gating fault anywhere on the way into the buffer shows up in any disabled cycle without a pop.
  a_no_push_off: assert property (
    @(posedge clk) disable iff (rst)
    !block_enable |=> count_q <= $past(count_q))
    else $error("command taken while disabled");
  a_word_frozen: assert property (
    @(posedge clk) disable iff (rst)
    (bit_mode && !apply_clr) |=> $stable(word_fields_q))
    else $error("word fields moved in bit mode");
  a_one_push: assert property (
    @(posedge clk) disable iff (rst)
    (do_push && !do_pop) |=> count_q == $past(count_q) + 2'd1)
    else $error("edge did not queue exactly one command");
  a_mode_held: assert property (
    @(posedge clk) disable iff (rst)
    block_enable |=> $stable(mode_q))
    else $error("mode changed while enabled");

endmodule

// [shift_cmd_sink.sv]
// Receiver model that accepts or stalls the buffered shift commands.
`timescale 1ns/1ns
module shift_cmd_sink (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic stall,
  input  wire logic out_valid,
  output logic      out_ready
);
  // ---------------------------------------------------------------------
  // Ready generation
  // ---------------------------------------------------------------------
  // Ready is registered, so a stall only bites from the following edge.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      out_ready <= 1'b1;
    else
      out_ready <= !stall;
  end
endmodule

// [bidirectional_shift_register_tb.sv]
// Self-checking testbench for the bidirectional shift register.
`timescale 1ns/1ns
module bidirectional_shift_register_tb;
  typedef struct packed
  {logic [1:0] op; logic b; shift_reg_pkg::word_t w;} row_t;
  logic                            clk, rst, en, mode, fp, bp, clr, fb, bb;
  logic                            stall, in_ready, out_valid, out_ready;
  logic                            mode_q;
  shift_reg_pkg::word_t            fw, bw;
  logic [7:0]                      bq, eb;
  shift_reg_pkg::word_t [7:0]      wq, ew;
  int                              miscompares, checked;
  row_t                            rows [10];

  bidirectional_shift_register dut (.clk(clk), .rst(rst),
    .block_enable(en), .double_word_mode(mode), .forward_shift_pulse(fp),
    .backward_shift_pulse(bp), .register_clear(clr), .forward_bit_in(fb),
    .backward_bit_in(bb), .forward_word_in(fw), .backward_word_in(bw),
    .out_ready(out_ready), .in_ready(in_ready), .out_valid(out_valid),
    .mode_q(mode_q), .bit_fields_q(bq), .word_fields_q(wq));
  shift_cmd_sink sink (.clk(clk), .rst(rst), .stall(stall),
    .out_valid(out_valid), .out_ready(out_ready));

  // ---------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------
  task automatic chk(input logic [266:0] seen, input logic [266:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: field or flag mismatch", $time);
    end
  endtask

  // Every call site sees the buffer either empty or full, so valid is
  // always the inverse of ready there.
  task automatic cmp(input logic rdy);
    chk({bq, wq, mode_q, in_ready, out_valid}, {eb, ew, mode, rdy, ~rdy});
  endtask

  // One command; the reference moves only while the block is enabled.
  task automatic op(input logic [1:0] o, input logic b,
                    input shift_reg_pkg::word_t w);
    @(posedge clk);
    fp <= (o == 2'h0);
    bp <= (o == 2'h1);
    clr <= (o == 2'h2);
    fb <= b;
    bb <= b;
    fw <= w;
    bw <= w;
    @(posedge clk);
    fp <= 1'b0;
    bp <= 1'b0;
    clr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    if (en && o == 2'h2) {eb, ew} = '0;
    else if (en && !mode) eb = (o == 2'h0) ? {eb[6:0], b} : {b, eb[7:1]};
    else if (en) ew = (o == 2'h0) ? {ew[6:0], w} : {w, ew[7:1]};
    cmp(1'b1);
  endtask

  task automatic set_mode(input logic m);
    @(posedge clk);
    en <= 1'b0;
    mode <= m;
    @(posedge clk);
    en <= 1'b1;
  endtask

  task automatic finish_test;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ---------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    repeat (1000) @(posedge clk);
    miscompares++;
    finish_test();
  end

  initial
  begin
    {rst, en, mode, fp, bp, clr, fb, bb, stall} = 9'h100;
    fw = '0;
    bw = '0;
    {eb, ew} = '0;
    rows = '{{2'h0, 1'b1, 32'hA5A5A5A5}, {2'h0, 1'b0, 32'h0000FFFF},
             {2'h0, 1'b1, 32'h00000001}, {2'h1, 1'b1, 32'h5A5A5A5A},
             {2'h2, 1'b0, 32'h00000003}, {2'h0, 1'b1, 32'h0000000A},
             {2'h0, 1'b0, 32'h00000034}, {2'h1, 1'b1, 32'h80000000},
             {2'h1, 1'b0, 32'h7FFFFFFF}, {2'h2, 1'b1, 32'h00000009}};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    cmp(1'b1);
    $display("test reset done");
    set_mode(1'b0);
    for (int i = 0; i < 10; i++)
    begin
      if (i == 5) set_mode(1'b1);
      op(rows[i].op, rows[i].b, rows[i].w);
    end
    $display("test rows done");
    @(posedge clk);
    en <= 1'b0;
    op(2'h0, 1'b1, 32'h12345678);
    op(2'h2, 1'b0, 32'h00000000);
    @(posedge clk);
    en <= 1'b1;
    fp <= 1'b1;
    fw <= 32'h00000007;
    repeat (4) @(posedge clk);
    fp <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    ew = {ew[6:0], 32'h00000007};
    cmp(1'b1);
    $display("test disabled and held pulse done");
    // Three pulses into a stalled two-entry buffer: the third is dropped.
    @(posedge clk);
    stall <= 1'b1;
    repeat (2) @(posedge clk);
    for (int k = 1; k < 4; k++)
    begin
      fp <= 1'b1;
      fw <= shift_reg_pkg::word_t'(k);
      @(posedge clk);
      fp <= 1'b0;
      @(posedge clk);
    end
    #1;
    cmp(1'b0);
    @(posedge clk);
    stall <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    ew = {ew[5:0], 32'h00000001, 32'h00000002};
    cmp(1'b1);
    $display("test stall done");
    // A reset in mid-run must clear filled fields and fall back to bits.
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    en <= 1'b0;
    mode <= 1'b0;
    #1;
    {eb, ew} = '0;
    cmp(1'b1);
    $display("test mid-run reset done");
    finish_test();
  end
endmodule
